// File: wdd_regs.svh
// register offsets, descriptor layout and field positions of the descriptor dma
`ifndef WDD_REGS_SVH
`define WDD_REGS_SVH
`define WDD_OFF_CMD      8'h00
`define WDD_OFF_TXHEAD   8'h04
`define WDD_OFF_RXHEAD   8'h08
`define WDD_OFF_STATUS   8'h0c
`define WDD_OFF_TXCUR    8'h10
`define WDD_OFF_RXCUR    8'h14
`define WDD_CMD_TXGO     0
`define WDD_CMD_RXGO     1
`define WDD_ST_TXBUSY    0
`define WDD_ST_RXBUSY    1
`define WDD_ST_OVERRUN   2
`define WDD_ST_TXWAIT    3
`define WDD_ST_RXWAIT    4
`define WDD_DW_LINK      32'h0000_0000
`define WDD_DW_LEN       32'h0000_000c
`define WDD_DW_RXDONE    32'h0000_0010
`define WDD_DW_RXSTAT    32'h0000_0014
`define WDD_DW_TXSTAT    32'h0000_0018
`define WDD_DW_TXDONE    32'h0000_001c
`define WDD_TX_DESC_LAST 3'd5
`define WDD_RX_DESC_LAST 3'd3
`define WDD_LEN_MSB      11
`define WDD_MORE_BIT     12
`define WDD_DONE_WORD    32'h0000_0001
`define WDD_NULL_LINK    32'h0000_0000
`define WDD_HDR_BASE     6'd24
`define WDD_HDR_ADDR4    6'd6
`define WDD_HDR_QOS      6'd2
`define WDD_FC_DATA      2'b10
`endif

// File: wdd_pkg.sv
// types and shared helpers of the descriptor dma
`include "wdd_regs.svh"
package wdd_pkg;
  typedef enum logic [3:0] {TX_IDLE, TX_DESC, TX_CMD, TX_RD, TX_OUT, TX_STAT,
    TX_DONE, TX_LINK, TX_WAIT, TX_RELOAD} tx_state_type;
  typedef enum logic [3:0] {RX_IDLE, RX_DESC, RX_FILL, RX_WR, RX_LEN, RX_STAT,
    RX_DONE, RX_LINK, RX_WAIT, RX_RELOAD} rx_state_type;
  typedef enum logic [1:0] {OWN_NONE, OWN_TX, OWN_RX} wdd_owner_type;

  // set beats clear in the same cycle
  function automatic logic sticky(input logic set, input logic old,
                                  input logic clr);
    sticky = set | (old & ~clr);
  endfunction : sticky

  function automatic logic [5:0] hdr_len(input logic [7:0] fc0,
                                         input logic [7:0] fc1);
    hdr_len = `WDD_HDR_BASE;
    if (fc1[0] && fc1[1])
      hdr_len = hdr_len + `WDD_HDR_ADDR4;
    if (fc0[3:2] == `WDD_FC_DATA && fc0[7])
      hdr_len = hdr_len + `WDD_HDR_QOS;
  endfunction : hdr_len
endpackage : wdd_pkg

// File: wdd_mem_if.sv
// word request channel from one engine to the memory arbiter
`timescale 1ns/1ns
interface wdd_mem_if;
  logic        req;
  logic        we;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic        ack;
  logic [31:0] rdata;
  modport client (output req, we, addr, wdata, input ack, rdata);
  modport server (input req, we, addr, wdata, output ack, rdata);
endinterface : wdd_mem_if

// File: wdd_mem_arb.sv
// arbiter sharing the host memory master between transmit and receive
`timescale 1ns/1ns
module wdd_mem_arb (
  input  wire logic         clock,
  input  wire logic         resetn,
  wdd_mem_if.server         tx,
  wdd_mem_if.server         rx,
  output logic              mem_req,
  output logic              mem_we,
  output logic [31:0]       mem_addr,
  output logic [31:0]       mem_wdata,
  input  wire logic         mem_ack,
  input  wire logic [31:0]  mem_rdata
);
  wdd_pkg::wdd_owner_type owner_q;
  wdd_pkg::wdd_owner_type sel;

  // receive first: its data backs up in a fifo that can overrun
  always_comb
  begin
    sel = owner_q;
    if (owner_q == wdd_pkg::OWN_NONE)
    begin
      if (rx.req)
        sel = wdd_pkg::OWN_RX;
      else if (tx.req)
        sel = wdd_pkg::OWN_TX;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      owner_q <= wdd_pkg::OWN_NONE;
    else if (mem_ack)
      owner_q <= wdd_pkg::OWN_NONE;
    else
      owner_q <= sel;
  end

  assign mem_req   = (sel == wdd_pkg::OWN_RX) ? rx.req
                   : (sel == wdd_pkg::OWN_TX) ? tx.req : 1'b0;
  assign mem_we    = (sel == wdd_pkg::OWN_RX) ? rx.we : tx.we;
  assign mem_addr  = (sel == wdd_pkg::OWN_RX) ? rx.addr : tx.addr;
  assign mem_wdata = (sel == wdd_pkg::OWN_RX) ? rx.wdata : tx.wdata;
  assign tx.ack    = mem_ack && (sel == wdd_pkg::OWN_TX);
  assign rx.ack    = mem_ack && (sel == wdd_pkg::OWN_RX);
  assign tx.rdata  = mem_rdata;
  assign rx.rdata  = mem_rdata;
endmodule : wdd_mem_arb

// File: wdd_hdr_pad.sv
// tracks byte position in a frame and flags the two header pad slots
`timescale 1ns/1ns
module wdd_hdr_pad (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        start,
  input  wire logic        step,
  input  wire logic [7:0]  data,
  output logic             pad_slot
);
  logic [5:0] pos_q;
  logic [7:0] fc0_q;
  logic [7:0] fc1_q;
  logic [5:0] len;

  // saturates: pad slots lie below 34, later bytes need no count
  always_ff @(posedge clock)
  begin
    if (!resetn)
      pos_q <= 6'h00;
    else if (start)
      pos_q <= 6'h00;
    else if (step && pos_q != 6'h3f)
      pos_q <= pos_q + 6'h01;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      fc0_q <= 8'h00;
      fc1_q <= 8'h00;
    end
    else if (step && pos_q == 6'h00)
      fc0_q <= data;
    else if (step && pos_q == 6'h01)
      fc1_q <= data;
  end

  assign len      = wdd_pkg::hdr_len(fc0_q, fc1_q);
  assign pad_slot = (len[1:0] != 2'b00) &&
                    (pos_q == len || pos_q == len + 6'h01);
endmodule : wdd_hdr_pad

// File: wdd_dma.sv
// descriptor-driven transmit and receive dma engine with register port
// Summary of operation
// - fetch descriptor, send words 2-5 command
// - fetch each buffer into transmit fifo
// - continuation fetches next link, resumes data
// - final descriptor: write status, check link
// - non-null link starts new frame
// - null link: wait go, reload or restart
// - single receive queue tolerating no descriptors
// - fill buffer until frame end or length
// - set done, length, continuation, final status
// - after each receive descriptor follow link
// - null receive link: wait go, reload/restart
// - stall receive data, flag fifo overrun
// - engine sets done after consuming descriptor
// - skip transmit pad bytes, never sent
// - insert receive pad bytes after header
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "wdd_regs.svh"
module wdd_dma (
  input  wire logic          CLOCK,
  input  wire logic          RESETN,
  input  wire logic [7:0]    REG_ADDR,
  input  wire logic [31:0]   REG_WDATA,
  input  wire logic          REG_WRITE,
  input  wire logic          REG_READ,
  output logic [31:0]        REG_RDATA,
  output logic               MEM_REQ,
  output logic               MEM_WE,
  output logic [31:0]        MEM_ADDR,
  output logic [31:0]        MEM_WDATA,
  input  wire logic          MEM_ACK,
  input  wire logic [31:0]   MEM_RDATA,
  output logic [127:0]       TX_CMD,
  output logic               TX_CMD_VALID,
  input  wire logic          TX_CMD_READY,
  output logic [7:0]         TX_DATA,
  output logic               TX_VALID,
  output logic               TX_LAST,
  input  wire logic          TX_READY,
  input  wire logic [31:0]   TX_STATUS,
  input  wire logic [7:0]    RX_DATA,
  input  wire logic          RX_VALID,
  input  wire logic          RX_LAST,
  output logic               RX_READY,
  input  wire logic [31:0]   RX_STATUS,
  input  wire logic          RX_OVERRUN
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);

  wdd_mem_if tmem ();
  wdd_mem_if rmem ();
  wdd_pkg::tx_state_type tst_q;
  wdd_pkg::rx_state_type rst_q;
  logic [31:0] tx_head_q, rx_head_q, tcur_q, rcur_q;
  logic        tx_go_q, rx_go_q, tx_pw_q, rx_pw_q, ovr_q;
  logic        tx_take_go, rx_take_go, tx_pad, rx_pad, tx_step, rx_take;
  logic [31:0] tdesc_q [0:5];
  logic [2:0]  tidx_q, ridx_w_q;
  logic        tfirst_q, treq_q, twe_q, rreq_q, rwe_q;
  logic [31:0] taddr_q, twdata_q, tword_q, tbaddr_q;
  logic [31:0] raddr_q, rwdata_q, rword_q, rbaddr_q, rlink_q;
  logic [11:0] trem_q, rblen_q, rcnt_q;
  logic [1:0]  tbyte_q, rbyte_q;
  logic        rfend_q, rfull, rlast;
  logic [7:0]  rbyte_in;
  logic        tmore;
  logic [31:0] status;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  assign tx_take_go = tx_go_q &&
    (tst_q == wdd_pkg::TX_IDLE || tst_q == wdd_pkg::TX_WAIT);
  assign rx_take_go = rx_go_q &&
    (rst_q == wdd_pkg::RX_IDLE || rst_q == wdd_pkg::RX_WAIT);
  assign status = {27'h0, rst_q == wdd_pkg::RX_WAIT,
    tst_q == wdd_pkg::TX_WAIT, ovr_q,
    rst_q != wdd_pkg::RX_IDLE && rst_q != wdd_pkg::RX_WAIT,
    tst_q != wdd_pkg::TX_IDLE && tst_q != wdd_pkg::TX_WAIT};

  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      tx_head_q <= 32'h0;
      rx_head_q <= 32'h0;
    end
    else if (REG_WRITE && REG_ADDR == `WDD_OFF_TXHEAD)
      tx_head_q <= REG_WDATA;
    else if (REG_WRITE && REG_ADDR == `WDD_OFF_RXHEAD)
      rx_head_q <= REG_WDATA;
  end

  // go and pointer-written flags live until the engine consumes them
  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      tx_go_q <= 1'b0;
      rx_go_q <= 1'b0;
      tx_pw_q <= 1'b0;
      rx_pw_q <= 1'b0;
      ovr_q   <= 1'b0;
    end
    else
    begin
      tx_go_q <= wdd_pkg::sticky(REG_WRITE && REG_ADDR == `WDD_OFF_CMD &&
        REG_WDATA[`WDD_CMD_TXGO], tx_go_q, tx_take_go);
      rx_go_q <= wdd_pkg::sticky(REG_WRITE && REG_ADDR == `WDD_OFF_CMD &&
        REG_WDATA[`WDD_CMD_RXGO], rx_go_q, rx_take_go);
      tx_pw_q <= wdd_pkg::sticky(REG_WRITE && REG_ADDR == `WDD_OFF_TXHEAD,
        tx_pw_q, tx_take_go);
      rx_pw_q <= wdd_pkg::sticky(REG_WRITE && REG_ADDR == `WDD_OFF_RXHEAD,
        rx_pw_q, rx_take_go);
      ovr_q   <= wdd_pkg::sticky(RX_OVERRUN, ovr_q, REG_WRITE &&
        REG_ADDR == `WDD_OFF_STATUS && REG_WDATA[`WDD_ST_OVERRUN]);
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
      REG_RDATA <= 32'h0;
    else if (!REG_READ)
      REG_RDATA <= 32'h0;
    else
      case (REG_ADDR)
        `WDD_OFF_CMD:    REG_RDATA <= {30'h0, rx_go_q, tx_go_q};
        `WDD_OFF_TXHEAD: REG_RDATA <= tx_head_q;
        `WDD_OFF_RXHEAD: REG_RDATA <= rx_head_q;
        `WDD_OFF_STATUS: REG_RDATA <= status;
        `WDD_OFF_TXCUR:  REG_RDATA <= tcur_q;
        `WDD_OFF_RXCUR:  REG_RDATA <= rcur_q;
        default:         REG_RDATA <= 32'h0;
      endcase
  end

  // ----------------------------------------------------------------
  // transmit engine
  // ----------------------------------------------------------------
  assign tmore        = tdesc_q[3][`WDD_MORE_BIT];
  assign TX_CMD       = {tdesc_q[5], tdesc_q[4], tdesc_q[3], tdesc_q[2]};
  assign TX_CMD_VALID = tst_q == wdd_pkg::TX_CMD;
  assign TX_DATA      = tword_q[7:0];
  assign TX_VALID     = tst_q == wdd_pkg::TX_OUT && !tx_pad;
  assign TX_LAST      = TX_VALID && trem_q == 12'h001 && !tmore;
  assign tx_step      = tst_q == wdd_pkg::TX_OUT && (tx_pad || TX_READY);
  assign tmem.req     = treq_q;
  assign tmem.we      = twe_q;
  assign tmem.addr    = taddr_q;
  assign tmem.wdata   = twdata_q;

  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      tst_q <= wdd_pkg::TX_IDLE;
      for (int i = 0; i < 6; i++)
        tdesc_q[i] <= 32'h0;
      {tcur_q, taddr_q, twdata_q, tword_q, tbaddr_q} <= 160'h0;
      {tidx_q, tbyte_q, trem_q} <= 17'h0;
      {tfirst_q, treq_q, twe_q} <= 3'b000;
    end
    else
      case (tst_q)
        wdd_pkg::TX_IDLE, wdd_pkg::TX_WAIT:
          if (tx_take_go)
          begin
            if (tst_q == wdd_pkg::TX_WAIT && !tx_pw_q)
              tst_q <= wdd_pkg::TX_RELOAD;
            else if (tx_head_q != `WDD_NULL_LINK)
            begin
              tcur_q   <= tx_head_q;
              tfirst_q <= 1'b1;
              tst_q    <= wdd_pkg::TX_DESC;
            end
          end
        wdd_pkg::TX_DESC:
          if (!treq_q)
          begin
            {treq_q, twe_q} <= 2'b10;
            taddr_q <= tcur_q + {27'h0, tidx_q, 2'b00};
          end
          else if (tmem.ack)
          begin
            treq_q <= 1'b0;
            tdesc_q[tidx_q] <= tmem.rdata;
            tidx_q <= tidx_q + 3'd1;
            if (tidx_q == `WDD_TX_DESC_LAST)
            begin
              tidx_q   <= 3'd0;
              trem_q   <= tdesc_q[3][`WDD_LEN_MSB:0];
              tbaddr_q <= tdesc_q[1];
              tst_q    <= tfirst_q ? wdd_pkg::TX_CMD : wdd_pkg::TX_RD;
            end
          end
        wdd_pkg::TX_CMD:
          if (TX_CMD_READY)
            tst_q <= wdd_pkg::TX_RD;
        wdd_pkg::TX_RD:
          if (trem_q == 12'h000)
            tst_q <= tmore ? wdd_pkg::TX_DONE : wdd_pkg::TX_STAT;
          else if (!treq_q)
          begin
            {treq_q, twe_q} <= 2'b10;
            taddr_q <= tbaddr_q;
          end
          else if (tmem.ack)
          begin
            treq_q   <= 1'b0;
            tword_q  <= tmem.rdata;
            tbyte_q  <= 2'd0;
            tbaddr_q <= tbaddr_q + 32'h4;
            tst_q    <= wdd_pkg::TX_OUT;
          end
        wdd_pkg::TX_OUT:
          if (tx_step)
          begin
            tword_q <= {8'h00, tword_q[31:8]};
            tbyte_q <= tbyte_q + 2'd1;
            trem_q  <= trem_q - 12'h001;
            if (tbyte_q == 2'd3 || trem_q == 12'h001)
              tst_q <= wdd_pkg::TX_RD;
          end
        wdd_pkg::TX_STAT, wdd_pkg::TX_DONE:
          if (!treq_q)
          begin
            {treq_q, twe_q} <= 2'b11;
            taddr_q  <= tcur_q + ((tst_q == wdd_pkg::TX_STAT) ?
                        `WDD_DW_TXSTAT : `WDD_DW_TXDONE);
            twdata_q <= (tst_q == wdd_pkg::TX_STAT) ? TX_STATUS
                        : `WDD_DONE_WORD;
          end
          else if (tmem.ack)
          begin
            treq_q <= 1'b0;
            if (tst_q == wdd_pkg::TX_STAT)
              tst_q <= wdd_pkg::TX_DONE;
            else if (tmore)
            begin
              tcur_q   <= tdesc_q[0];
              tfirst_q <= 1'b0;
              tst_q    <= wdd_pkg::TX_DESC;
            end
            else
              tst_q <= wdd_pkg::TX_LINK;
          end
        wdd_pkg::TX_LINK:
          if (tdesc_q[0] != `WDD_NULL_LINK)
          begin
            tcur_q   <= tdesc_q[0];
            tfirst_q <= 1'b1;
            tst_q    <= wdd_pkg::TX_DESC;
          end
          else
            tst_q <= wdd_pkg::TX_WAIT;
        wdd_pkg::TX_RELOAD:
          if (!treq_q)
          begin
            {treq_q, twe_q} <= 2'b10;
            taddr_q <= tcur_q + `WDD_DW_LINK;
          end
          else if (tmem.ack)
          begin
            treq_q     <= 1'b0;
            tdesc_q[0] <= tmem.rdata;
            tst_q      <= wdd_pkg::TX_LINK;
          end
        default:
          tst_q <= wdd_pkg::TX_IDLE;
      endcase
  end

  wdd_hdr_pad u_tx_pad (
    .clock    (CLOCK),
    .resetn   (RESETN),
    .start    (TX_CMD_VALID && TX_CMD_READY),
    .step     (tx_step),
    .data     (tword_q[7:0]),
    .pad_slot (tx_pad)
  );

  // ----------------------------------------------------------------
  // receive engine, one queue; the pcu holds data while we lack buffers
  // ----------------------------------------------------------------
  assign rfull    = rcnt_q == rblen_q;
  assign RX_READY = rst_q == wdd_pkg::RX_FILL && !rfull && !rx_pad;
  assign rx_take  = rst_q == wdd_pkg::RX_FILL && !rfull &&
                    (rx_pad || RX_VALID);
  assign rlast    = !rx_pad && RX_LAST;
  assign rbyte_in = rx_pad ? 8'h00 : RX_DATA;
  assign rmem.req   = rreq_q;
  assign rmem.we    = rwe_q;
  assign rmem.addr  = raddr_q;
  assign rmem.wdata = rwdata_q;

  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      rst_q <= wdd_pkg::RX_IDLE;
      {rcur_q, raddr_q, rwdata_q, rword_q, rbaddr_q, rlink_q} <= 192'h0;
      {rblen_q, rcnt_q, rbyte_q, ridx_w_q} <= 29'h0;
      {rfend_q, rreq_q, rwe_q} <= 3'b000;
    end
    else
      case (rst_q)
        wdd_pkg::RX_IDLE, wdd_pkg::RX_WAIT:
          if (rx_take_go)
          begin
            if (rst_q == wdd_pkg::RX_WAIT && !rx_pw_q)
              rst_q <= wdd_pkg::RX_RELOAD;
            else if (rx_head_q != `WDD_NULL_LINK)
            begin
              rcur_q <= rx_head_q;
              rst_q  <= wdd_pkg::RX_DESC;
            end
          end
        wdd_pkg::RX_DESC:
          if (!rreq_q)
          begin
            {rreq_q, rwe_q} <= 2'b10;
            raddr_q <= rcur_q + {27'h0, ridx_w_q, 2'b00};
          end
          else if (rmem.ack)
          begin
            rreq_q   <= 1'b0;
            ridx_w_q <= ridx_w_q + 3'd1;
            if (ridx_w_q == 3'd0)
              rlink_q <= rmem.rdata;
            if (ridx_w_q == 3'd1)
              rbaddr_q <= rmem.rdata;
            if (ridx_w_q == `WDD_RX_DESC_LAST)
            begin
              rblen_q  <= rmem.rdata[`WDD_LEN_MSB:0];
              ridx_w_q <= 3'd0;
              {rcnt_q, rbyte_q, rword_q} <= 46'h0;
              rfend_q  <= 1'b0;
              rst_q    <= wdd_pkg::RX_FILL;
            end
          end
        wdd_pkg::RX_FILL:
          if (rx_take)
          begin
            rword_q <= rword_q | ({24'h0, rbyte_in} << {rbyte_q, 3'b000});
            rbyte_q <= rbyte_q + 2'd1;
            rcnt_q  <= rcnt_q + 12'h001;
            rfend_q <= rlast;
            if (rbyte_q == 2'd3 || rlast || rcnt_q + 12'h001 == rblen_q)
              rst_q <= wdd_pkg::RX_WR;
          end
          else if (rfull)
            rst_q <= wdd_pkg::RX_LEN;
        wdd_pkg::RX_WR:
          if (!rreq_q)
          begin
            {rreq_q, rwe_q} <= 2'b11;
            raddr_q  <= rbaddr_q;
            rwdata_q <= rword_q;
          end
          else if (rmem.ack)
          begin
            rreq_q   <= 1'b0;
            rbaddr_q <= rbaddr_q + 32'h4;
            rword_q  <= 32'h0;
            rbyte_q  <= 2'd0;
            rst_q    <= (rfend_q || rfull) ? wdd_pkg::RX_LEN
                        : wdd_pkg::RX_FILL;
          end
        wdd_pkg::RX_LEN, wdd_pkg::RX_STAT, wdd_pkg::RX_DONE:
          if (!rreq_q)
          begin
            {rreq_q, rwe_q} <= 2'b11;
            case (rst_q)
              wdd_pkg::RX_LEN:
              begin
                raddr_q  <= rcur_q + `WDD_DW_LEN;
                rwdata_q <= {19'h0, !rfend_q, rcnt_q};
              end
              wdd_pkg::RX_STAT:
              begin
                raddr_q  <= rcur_q + `WDD_DW_RXSTAT;
                rwdata_q <= RX_STATUS;
              end
              default:
              begin
                raddr_q  <= rcur_q + `WDD_DW_RXDONE;
                rwdata_q <= `WDD_DONE_WORD;
              end
            endcase
          end
          else if (rmem.ack)
          begin
            rreq_q <= 1'b0;
            case (rst_q)
              wdd_pkg::RX_LEN:
                rst_q <= rfend_q ? wdd_pkg::RX_STAT : wdd_pkg::RX_DONE;
              wdd_pkg::RX_STAT:
                rst_q <= wdd_pkg::RX_DONE;
              default:
                rst_q <= wdd_pkg::RX_LINK;
            endcase
          end
        wdd_pkg::RX_LINK:
          if (rlink_q != `WDD_NULL_LINK)
          begin
            rcur_q <= rlink_q;
            rst_q  <= wdd_pkg::RX_DESC;
          end
          else
            rst_q <= wdd_pkg::RX_WAIT;
        wdd_pkg::RX_RELOAD:
          if (!rreq_q)
          begin
            {rreq_q, rwe_q} <= 2'b10;
            raddr_q <= rcur_q + `WDD_DW_LINK;
          end
          else if (rmem.ack)
          begin
            rreq_q  <= 1'b0;
            rlink_q <= rmem.rdata;
            rst_q   <= wdd_pkg::RX_LINK;
          end
        default:
          rst_q <= wdd_pkg::RX_IDLE;
      endcase
  end

  // a new frame begins after the byte marked last
  wdd_hdr_pad u_rx_pad (
    .clock    (CLOCK),
    .resetn   (RESETN),
    .start    (rx_take && rlast),
    .step     (rx_take),
    .data     (RX_DATA),
    .pad_slot (rx_pad)
  );

  wdd_mem_arb u_arb (
    .clock     (CLOCK),
    .resetn    (RESETN),
    .tx        (tmem),
    .rx        (rmem),
    .mem_req   (MEM_REQ),
    .mem_we    (MEM_WE),
    .mem_addr  (MEM_ADDR),
    .mem_wdata (MEM_WDATA),
    .mem_ack   (MEM_ACK),
    .mem_rdata (MEM_RDATA)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_tx_cmd_hold: assert property (TX_CMD_VALID && !TX_CMD_READY |=>
    TX_CMD_VALID && $stable(TX_CMD)) else $error("command dropped");
  a_tx_byte_hold: assert property (TX_VALID && !TX_READY |=>
    TX_VALID && $stable(TX_DATA)) else $error("tx byte dropped");
  a_tx_pad_skip: assert property (tx_pad && tst_q == wdd_pkg::TX_OUT
    |-> !TX_VALID ##1 trem_q == $past(trem_q) - 12'h001)
    else $error("pad sent");
  a_tx_more_next: assert property (tst_q == wdd_pkg::TX_DONE && tmem.ack
    && tmore |=> tst_q == wdd_pkg::TX_DESC && !tfirst_q)
    else $error("continuation not followed");
  a_tx_null_wait: assert property (tst_q == wdd_pkg::TX_LINK &&
    tdesc_q[0] == 32'h0 |=> tst_q == wdd_pkg::TX_WAIT)
    else $error("null link followed");
  a_rx_full_stall: assert property (rfull |-> !RX_READY)
    else $error("buffer overfilled");
  a_rx_pad_insert: assert property (rx_pad |-> !RX_READY)
    else $error("pad slot consumed data");
  a_rx_done_write: assert property (rst_q == wdd_pkg::RX_DONE && rreq_q
    |-> rwe_q && rwdata_q == 32'h1) else $error("done word wrong");
  a_ovr_sticky: assert property (RX_OVERRUN |=> ovr_q)
    else $error("overrun lost");
endmodule : wdd_dma

// File: wdd_host_mem.sv
// host memory model answering word requests
`timescale 1ns/1ns
module wdd_host_mem (
  input  wire logic        clock,
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  output logic             ack = 1'b0,
  output logic [31:0]      rdata = 32'h0
);
  logic [31:0] m [0:255];
  logic        slow_q = 1'b0;
  // each request waits one cycle and acks on the next, so latency is fixed
  always @(posedge clock)
  begin
    ack <= 1'b0;
    rdata <= ~rdata;
    if (req && !ack)
    begin
      slow_q <= ~slow_q;
      if (slow_q)
      begin
        ack <= 1'b1;
        rdata <= m[addr[9:2]];
        if (we)
          m[addr[9:2]] <= wdata;
      end
    end
  end
endmodule : wdd_host_mem

// File: wdd_dma_test.sv
// self-checking bench for the descriptor dma
`timescale 1ns/1ns
`include "wdd_regs.svh"
module wdd_dma_test;
  logic CLOCK = 1'b0, RESETN = 1'b0, REG_WRITE = 1'b0, REG_READ = 1'b0;
  logic [7:0] REG_ADDR = 8'h00, TX_DATA, RX_DATA = 8'h08;
  logic [31:0] REG_WDATA = 32'h0, REG_RDATA, MEM_ADDR, MEM_WDATA, MEM_RDATA, d;
  logic MEM_REQ, MEM_WE, MEM_ACK, TX_CMD_VALID, TX_VALID, TX_LAST, RX_READY;
  logic RX_VALID = 1'b0, RX_LAST = 1'b0, RX_OVERRUN = 1'b0, TX_READY = 1'b0;
  logic [127:0] TX_CMD, cmd_q;
  logic [63:0] ex = 64'h88776655_44332208;
  logic [8:0] txq [$];
  int miscompares = 0, checked = 0;
  wdd_dma uut (.CLOCK(CLOCK), .RESETN(RESETN), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WRITE(REG_WRITE), .REG_READ(REG_READ),
    .REG_RDATA(REG_RDATA), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE),
    .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK),
    .MEM_RDATA(MEM_RDATA), .TX_CMD(TX_CMD), .TX_CMD_VALID(TX_CMD_VALID),
    .TX_CMD_READY(TX_READY), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID),
    .TX_LAST(TX_LAST), .TX_READY(TX_READY), .TX_STATUS(32'h0000_00a5),
    .RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .RX_LAST(RX_LAST),
    .RX_READY(RX_READY), .RX_STATUS(32'h0000_5a00), .RX_OVERRUN(RX_OVERRUN));
  wdd_host_mem mem (.clock(CLOCK), .req(MEM_REQ), .we(MEM_WE),
    .addr(MEM_ADDR), .wdata(MEM_WDATA), .ack(MEM_ACK), .rdata(MEM_RDATA));
  initial
  begin
    forever #5 CLOCK = ~CLOCK;
  end
  // ready every other cycle, so both hold rules get exercised
  always @(posedge CLOCK)
  begin
    TX_READY <= ~TX_READY;
    if (TX_VALID && TX_READY)
      txq.push_back({TX_LAST, TX_DATA});
    if (TX_CMD_VALID && TX_READY)
      cmd_q <= TX_CMD;
  end
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_WDATA <= v;
    REG_WRITE <= 1'b1;
    @(posedge CLOCK);
    REG_WRITE <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_READ <= 1'b1;
    @(posedge CLOCK);
    REG_READ <= 1'b0;
    #1 d = REG_RDATA;
  endtask : rd
  task automatic rx_byte(input logic [7:0] v, input logic last);
    RX_DATA <= v;
    RX_VALID <= 1'b1;
    RX_LAST <= last;
    do @(negedge CLOCK); while (RX_READY !== 1'b1);
    @(posedge CLOCK);
  endtask : rx_byte
  // byte 0 marks a qos data frame: 26-byte header, two pad bytes
  function automatic logic [7:0] pat(input int k);
    pat = (k == 0) ? 8'h88 : 8'(k);
  endfunction : pat
  task automatic chk(input string what, input logic [127:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict
  initial
  begin
    #300000;
    miscompares++;
    print_verdict;
  end
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem.m[i] = 32'h0;
    // two-part frame, more flag on the first part only
    mem.m[16] = 32'h80;
    mem.m[17] = 32'h100;
    mem.m[18] = 32'h11;
    mem.m[19] = 32'h1004;
    mem.m[20] = 32'h33;
    mem.m[21] = 32'h44;
    mem.m[33] = 32'h110;
    mem.m[35] = 32'h4;
    mem.m[64] = ex[31:0];
    mem.m[68] = ex[63:32];
    mem.m[49] = 32'h140;
    mem.m[51] = 32'h10;
    repeat (12) @(posedge CLOCK);
    RESETN <= 1'b1;
    @(negedge CLOCK);
    chk("rx_wait", RX_READY, 0);
    wr(`WDD_OFF_TXHEAD, 32'h40);
    wr(`WDD_OFF_CMD, 32'h1);
    wr(`WDD_OFF_RXHEAD, 32'hc0);
    wr(`WDD_OFF_CMD, 32'h2);
    for (int i = 0; i < 4; i++)
      rx_byte(ex[8*i+:8], i == 3);
    RX_VALID <= 1'b0;
    for (int i = 0; i < 3000 && (mem.m[39] !== 1 || mem.m[52] !== 1); i++)
      @(posedge CLOCK);
    chk("tx_cmd", cmd_q, {32'h44, 32'h33, 32'h1004, 32'h11});
    chk("tx_count", txq.size(), 8);
    for (int i = 0; i < 8; i++)
      chk("tx_byte", txq[i], {i == 7, ex[8*i+:8]});
    chk("tx_done_a", mem.m[23], 1);
    chk("tx_stat", mem.m[38], 32'ha5);
    chk("tx_done_b", mem.m[39], 1);
    chk("rx_buf", mem.m[80], ex[31:0]);
    chk("rx_len", mem.m[51], 32'h4);
    chk("rx_stat", mem.m[53], 32'h5a00);
    chk("rx_done", mem.m[52], 1);
    @(posedge CLOCK);
    RX_OVERRUN <= 1'b1;
    @(posedge CLOCK);
    RX_OVERRUN <= 1'b0;
    rd(`WDD_OFF_STATUS);
    chk("status", d & 32'h1c, 32'h1c);
    wr(`WDD_OFF_STATUS, 32'h4);
    rd(`WDD_OFF_STATUS);
    chk("st_clear", d & 32'h4, 0);
    rd(`WDD_OFF_TXHEAD);
    chk("tx_head", d, 32'h40);
    rd(8'hfc);
    chk("unmapped", d, 0);
    // go without pointer rewrite: both engines reread the last link
    mem.m[32] = 32'ha0;
    mem.m[41] = 32'h180;
    mem.m[43] = 32'h20;
    mem.m[48] = 32'he0;
    mem.m[57] = 32'h200;
    mem.m[59] = 32'h40;
    for (int k = 0; k < 32; k++)
      mem.m[96 + k / 4][8 * (k % 4) +: 8] = pat(k);
    wr(`WDD_OFF_CMD, 32'h3);
    for (int k = 0; k < 30; k++)
      rx_byte(pat(k), k == 29);
    RX_VALID <= 1'b0;
    for (int i = 0; i < 3000 && (mem.m[47] !== 1 || mem.m[60] !== 1); i++)
      @(posedge CLOCK);
    chk("tx_count2", txq.size(), 38);
    for (int j = 0; j < 30; j++)
      chk("tx_pad", txq[8+j], {j == 29, pat(j < 26 ? j : j+2)});
    chk("rx_pad", mem.m[134], 32'h0000_1918);
    chk("rx_tail", mem.m[135], 32'h1d1c_1b1a);
    chk("rx_len2", mem.m[59], 32'h20);
    chk("rx_done2", mem.m[60], 1);
    chk("tx_done2", mem.m[47], 1);
    print_verdict;
  end
endmodule : wdd_dma_test
